// File: hdl/ssf_flags.sv
// Purpose: serial port status flags, clearing sequences and requests
// Assumes: peripheral-role byte shifter on the link clock, msb first
// Notes: controller-role shifting and clock rate logic live elsewhere
`timescale 1ns/1ns
module ssf_flags
  import ssf_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link clock and pins
  input wire logic clk_link_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // cpu accesses, one-cycle strobes
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic status_rd_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic serial_port_enable_i,
  input wire logic controller_role_select_i,
  input wire logic select_pin_ignore_i,
  // control and status out
  output logic serial_port_enable_o,
  output logic controller_role_select_o,
  output logic select_pin_ignore_o,
  output logic [7:0] status_o,
  output logic [7:0] rx_data_o,
  output logic rx_stall_o,
  // interrupt requests
  output logic irq_tx_o,
  output logic irq_rx_err_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic en_reg;
  logic role_reg;
  logic ign_reg;
  logic done_reg;
  logic write_collision_flag_reg;
  logic slave_select_error_flag_reg;
  logic mode_fault_flag_reg;
  logic done_arm_reg;
  logic write_collision_flag_arm_reg;
  logic mode_fault_flag_arm_reg;
  logic [7:0] tx_hold_reg;
  logic [7:0] rx_data_reg;
  logic [2:0] tgl_sync_reg;
  logic [1:0] mid_sync_reg;
  logic [2:0] sel_sync_reg;
  logic pend_reg;
  logic [1:0] lrst_sync_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] sh_in_reg;
  logic [7:0] sh_out_reg;
  logic [7:0] lk_word_reg;
  logic lk_tgl_reg;
  logic lk_mid_reg;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_out_data;

  // ---------------------------------------------------------------
  // link domain: byte shifter on the link clock
  // ---------------------------------------------------------------
  // local reset follows system reset or a disabled port
  always_ff @(posedge clk_link_i) begin
    lrst_sync_reg <= {lrst_sync_reg[0], rst_i | ~en_reg};
  end
  wire lk_rst = lrst_sync_reg[1];
  wire [7:0] sh_in_next = {sh_in_reg[6:0], mosi_i};
  wire lk_last = (bit_cnt_reg == SSF_LAST_BIT);

  // shift while selected; the word holds for a whole byte time
  always_ff @(posedge clk_link_i) begin
    if (lk_rst | sel_n_i) begin
      bit_cnt_reg <= SSF_FIRST_BIT;
      sh_out_reg <= tx_hold_reg; // hold is frozen while a byte runs
      lk_mid_reg <= 1'b0;
      if (lk_rst) begin
        lk_tgl_reg <= 1'b0;
        lk_word_reg <= SSF_DATA_RST;
        sh_in_reg <= SSF_DATA_RST;
      end
    end else begin
      sh_in_reg <= sh_in_next;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      lk_mid_reg <= ~lk_last;
      if (lk_last) begin
        lk_word_reg <= sh_in_next;
        lk_tgl_reg <= ~lk_tgl_reg;
        sh_out_reg <= tx_hold_reg;
      end else begin
        sh_out_reg <= {sh_out_reg[6:0], 1'b0};
      end
    end
  end

  // drive only while selected in peripheral role
  assign miso_o = sh_out_reg[7];
  assign miso_oe_o = ~sel_n_i & en_reg & ~role_reg;

  // ---------------------------------------------------------------
  // crossings into the system domain
  // ---------------------------------------------------------------
  // toggle carries the byte event; third stage only feeds edge detect
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tgl_sync_reg <= 3'h0;
      mid_sync_reg <= 2'h0;
      sel_sync_reg <= 3'h7;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], lk_tgl_reg};
      mid_sync_reg <= {mid_sync_reg[0], lk_mid_reg};
      sel_sync_reg <= {sel_sync_reg[1:0], sel_n_i};
    end
  end
  wire byte_evt = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  wire busy = mid_sync_reg[1];
  wire sel_n = sel_sync_reg[1];
  wire sel_rise = sel_sync_reg[1] & ~sel_sync_reg[2];

  // a byte waits here if the buffer is full, so none is dropped
  // pending drops on the accepting edge, else one word is pushed twice
  wire pend = pend_reg | byte_evt;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend & ~buf_in_ready;
    end
  end
  assign rx_stall_o = pend & ~buf_in_ready;

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  // draining stalls while the cpu reads, so the read sees a steady byte
  wire drain_ready = ~data_rd_i;
  wire drain = buf_out_valid & drain_ready;

  ssf_buf2 #(
    .W(SSF_DATA_W),
    .DEPTH(SSF_BUF_DEPTH)
  ) u_rx_buf (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(pend),
    .in_ready_o(buf_in_ready),
    .in_data_i(lk_word_reg),
    .out_valid_o(buf_out_valid),
    .out_ready_i(drain_ready),
    .out_data_o(buf_out_data)
  );

  // ---------------------------------------------------------------
  // event and clear decode
  // ---------------------------------------------------------------
  wire data_acc = data_wr_i | data_rd_i;
  wire write_collision_flag_evt = data_wr_i & busy;
  wire write_collision_flag_clr = write_collision_flag_arm_reg & data_acc;
  wire done_clr = done_arm_reg & data_acc;
  wire mode_fault_flag_clr = mode_fault_flag_arm_reg & ctrl_wr_i;
  wire slave_select_error_flag_evt = sel_rise & busy & en_reg & ~role_reg;
  // only a disabling control write clears
  wire slave_select_error_flag_clr = ctrl_wr_i & ~serial_port_enable_i;
  // select low while in controller role
  wire mode_fault_flag_evt = en_reg & role_reg & ~ign_reg & ~sel_n;
  // capture only the first byte since the last clear
  wire rx_take = drain & (~done_reg | done_clr);

  // ---------------------------------------------------------------
  // flags, set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      slave_select_error_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
    end else begin
      done_reg <= drain | (done_reg & ~done_clr);
      write_collision_flag_reg <= write_collision_flag_evt | (write_collision_flag_reg & ~write_collision_flag_clr);
      slave_select_error_flag_reg <= slave_select_error_flag_evt | (slave_select_error_flag_reg & ~slave_select_error_flag_clr);
      mode_fault_flag_reg <= mode_fault_flag_evt | (mode_fault_flag_reg & ~mode_fault_flag_clr);
    end
  end

  // status read with done, collision or mode fault set arms its clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_arm_reg <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else begin
      done_arm_reg <= done_reg & (done_arm_reg | status_rd_i) & ~done_clr;
      write_collision_flag_arm_reg <= write_collision_flag_reg & (write_collision_flag_arm_reg | status_rd_i) & ~write_collision_flag_clr;
      mode_fault_flag_arm_reg <= mode_fault_flag_reg & (mode_fault_flag_arm_reg | status_rd_i) & ~mode_fault_flag_clr;
    end
  end

  // ---------------------------------------------------------------
  // control bits and data registers
  // ---------------------------------------------------------------
  // a fault overrides the enable and role bits of a control write in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      en_reg <= SSF_EN_RST;
      role_reg <= SSF_ROLE_RST;
      ign_reg <= SSF_IGN_RST;
    end else begin
      if (ctrl_wr_i) ign_reg <= select_pin_ignore_i;
      if (mode_fault_flag_evt) begin
        en_reg <= 1'b0;
        role_reg <= 1'b0;
      end else if (ctrl_wr_i) begin
        en_reg <= serial_port_enable_i;
        role_reg <= controller_role_select_i;
      end
    end
  end

  // a colliding write is dropped so the shifted byte is kept
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_hold_reg <= SSF_DATA_RST;
      rx_data_reg <= SSF_DATA_RST;
    end else begin
      if (data_wr_i & ~busy) tx_hold_reg <= wdata_i;
      if (rx_take) rx_data_reg <= buf_out_data;
    end
  end

  // ---------------------------------------------------------------
  // outputs and requests
  // ---------------------------------------------------------------
  assign serial_port_enable_o = en_reg;
  assign controller_role_select_o = role_reg;
  assign select_pin_ignore_o = ign_reg;
  assign rx_data_o = rx_data_reg;
  // low nibble stays zero, no overrun bit exists
  assign status_o = {done_reg, write_collision_flag_reg, slave_select_error_flag_reg, mode_fault_flag_reg, 4'h0};
  assign irq_tx_o = done_reg;
  assign irq_rx_err_o = mode_fault_flag_reg & ~ign_reg;
  // collision and select error feed no request
  assign irq_o = irq_tx_o | irq_rx_err_o;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_write_collision_flag_on_busy: assert property (
    data_wr_i & busy |=> write_collision_flag_reg)
    else $error("collision flag not set on busy write");
  a_tx_kept_busy: assert property (
    data_wr_i & busy |=> $stable(tx_hold_reg))
    else $error("colliding write changed the transmit byte");
  a_write_collision_flag_no_irq: assert property (
    write_collision_flag_evt & ~drain & ~mode_fault_flag_evt & ~ctrl_wr_i & ~irq_o |=> ~irq_o)
    else $error("collision raised a request");
  a_write_collision_flag_seq_clear: assert property (
    write_collision_flag_reg & status_rd_i & ~data_acc ##1 data_acc & ~write_collision_flag_evt
    |=> ~write_collision_flag_reg)
    else $error("collision flag survived its clear sequence");
  a_write_collision_flag_no_early: assert property (
    write_collision_flag_reg & ~write_collision_flag_arm_reg & ~status_rd_i |=> write_collision_flag_reg)
    else $error("collision flag cleared without status read");
  a_rx_first_kept: assert property (
    done_reg & ~done_clr |=> $stable(rx_data_reg))
    else $error("receive byte overwritten while done set");
  a_no_overrun: assert property (
    status_o[3:0] == 4'h0)
    else $error("unexpected status bit set");
  a_slave_select_error_flag_set: assert property (
    slave_select_error_flag_evt |=> slave_select_error_flag_reg)
    else $error("select error not flagged");
  a_slave_select_error_flag_hold: assert property (
    slave_select_error_flag_reg & ~slave_select_error_flag_clr |=> slave_select_error_flag_reg)
    else $error("select error cleared without disable");
  a_done_set: assert property (
    byte_evt & buf_in_ready & ~buf_out_valid ##1 ~data_rd_i
    |=> done_reg)
    else $error("done flag late after byte");
  a_irq_tx: assert property (
    $rose(done_reg) |-> irq_tx_o & irq_o)
    else $error("transmitter request missing");
  a_mode_fault_flag_set: assert property (
    en_reg & role_reg & ~ign_reg & ~sel_n |=> mode_fault_flag_reg)
    else $error("mode fault not flagged");
  a_mode_fault_flag_gate: assert property (
    ign_reg |-> ~irq_rx_err_o)
    else $error("error request while select ignored");
  a_irq_sources: assert property (
    irq_o |-> done_reg | mode_fault_flag_reg)
    else $error("request without done or fault");
  a_mode_fault_flag_disable: assert property (
    mode_fault_flag_evt |=> ~en_reg & ~role_reg & mode_fault_flag_reg)
    else $error("fault did not disable the port");
  a_mode_fault_flag_clear: assert property (
    mode_fault_flag_arm_reg & ctrl_wr_i & ~mode_fault_flag_evt |=> ~mode_fault_flag_reg)
    else $error("mode fault survived its clear sequence");
  a_irq_merge: assert property (
    irq_o == (done_reg | (mode_fault_flag_reg & ~ign_reg)))
    else $error("merged request mismatch");

  c_byte_done: cover property (drain ##1 done_reg);
  c_collision: cover property (write_collision_flag_evt ##[1:20] write_collision_flag_clr);
  c_overrun_drop: cover property (done_reg & drain & ~done_clr);
  c_mode_fault: cover property (mode_fault_flag_evt ##[1:20] mode_fault_flag_clr);
endmodule // ssf_flags

// File: hdl/ssf_pkg.sv
// Purpose: shared constants for the serial port status flag block
// Assumes: one byte per transfer, msb first
// Notes: status vector layout mirrors the status register bit order
package ssf_pkg;
  // ---------------------------------------------------------------
  // data and buffer shape
  // ---------------------------------------------------------------
  localparam int SSF_DATA_W = 8;
  localparam int SSF_BUF_DEPTH = 2;
  localparam logic [2:0] SSF_LAST_BIT = 3'h7;
  localparam logic [2:0] SSF_FIRST_BIT = 3'h0;
  localparam logic [7:0] SSF_DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // status vector bit positions
  // ---------------------------------------------------------------
  localparam int SSF_ST_DONE = 7;
  localparam int SSF_ST_WRITE_COLLISION_FLAG = 6;
  localparam int SSF_ST_SLAVE_SELECT_ERROR_FLAG = 5;
  localparam int SSF_ST_MODE_FAULT_FLAG = 4;

  // ---------------------------------------------------------------
  // control reset values: port off, controller role, select in use
  // ---------------------------------------------------------------
  localparam logic SSF_EN_RST = 1'b0;
  localparam logic SSF_ROLE_RST = 1'b1;
  localparam logic SSF_IGN_RST = 1'b0;
endpackage

// File: hdl/ssf_buf2.sv
// Purpose: small valid/ready buffer, flip-flop storage
// Assumes: one clock, synchronous active high reset
// Notes: depth must be a power of two
`timescale 1ns/1ns
module ssf_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // honest full and empty from the fill count
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];

  // storage written only on an accepted word
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push) cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // ssf_buf2

// File: testbench/ssf_link_model.sv
// Purpose: external serial controller driving the link pins
// Assumes: link clock idles low and runs inside frames, or with select high to settle the link side
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ns
module ssf_link_model (
  // link pins toward the block
  output logic clk_link_o,
  output logic sel_n_o,
  output logic mosi_o
);
  // ---------------------------------------------------------------
  // pin state and frame tasks
  // ---------------------------------------------------------------
  // half period of the 32 ns link clock
  localparam int HALF = 16;

  // idle pins: clock low, not selected
  initial begin
    clk_link_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // clocks with select high, only to settle the link side after reset
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #HALF clk_link_o = 1'b1;
      #HALF clk_link_o = 1'b0;
    end
  endtask

  // shift nbits of b msb first; lst raises select afterwards
  task automatic send(input logic [7:0] b, input int nbits, input logic lst);
    sel_n_o = 1'b0;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi_o = b[i];
      #HALF clk_link_o = 1'b1;
      #HALF clk_link_o = 1'b0;
    end
    if (lst) begin
      #HALF sel_n_o = 1'b1;
      // no stale level once the line is released
      mosi_o = ~mosi_o;
    end
  endtask

  // hold select at a level with the clock stopped
  task automatic select(input logic lvl);
    sel_n_o = lvl;
  endtask
endmodule // ssf_link_model

// File: testbench/test_spi_status_flags_and_irq.sv
// Purpose: self-checking bench for the status flag and request block
// Assumes: strobes driven 2 ns after the system clock edge
// Notes: flag waits are bounded; the watchdog ends a hang
`timescale 1ns/1ns
module test_spi_status_flags_and_irq
  import ssf_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk_sys_i, rst_i, clk_link, sel_n, mosi, miso, miso_oe;
  logic data_wr, data_rd, status_rd, ctrl_wr, en_in, role_in, ign_in;
  logic en_out, role_out, ign_out, rx_stall, irq_tx, irq_rx_err, irq;
  logic [7:0] wdata, status, rx_data;
  int mismatches = 0;
  int total_checks = 0;
  // packed views of the requests and the control bits
  wire [7:0] irqv = {5'h00, irq_tx, irq_rx_err, irq};
  wire [7:0] ctrlv = {5'h00, en_out, role_out, ign_out};

  ssf_link_model link (.clk_link_o(clk_link), .sel_n_o(sel_n),
    .mosi_o(mosi));
  ssf_flags dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .clk_link_i(clk_link), .sel_n_i(sel_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .data_wr_i(data_wr),
    .data_rd_i(data_rd), .status_rd_i(status_rd), .ctrl_wr_i(ctrl_wr),
    .wdata_i(wdata), .serial_port_enable_i(en_in),
    .controller_role_select_i(role_in), .select_pin_ignore_i(ign_in),
    .serial_port_enable_o(en_out), .controller_role_select_o(role_out),
    .select_pin_ignore_o(ign_out), .status_o(status), .rx_data_o(rx_data),
    .rx_stall_o(rx_stall), .irq_tx_o(irq_tx), .irq_rx_err_o(irq_rx_err),
    .irq_o(irq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask

  // one-cycle strobe set {data wr, data rd, status rd, ctrl wr}
  task automatic cpu(input logic [3:0] s, input logic [7:0] wd,
    input logic [2:0] c);
    cyc(1);
    {data_wr, data_rd, status_rd, ctrl_wr} = s;
    wdata = wd;
    {en_in, role_in, ign_in} = c;
    cyc(1);
    {data_wr, data_rd, status_rd, ctrl_wr} = 4'h0;
    cyc(1);
  endtask

  // bounded wait for a status bit; a miss shows in the next compare
  task automatic wait_st(input int idx);
    int n;
    n = 0;
    while (status[idx] !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    cyc(1);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("status", status, 8'h00);
    chk("irq", irqv, 8'h00);
    chk("ctrl", ctrlv, {5'h00, SSF_EN_RST, SSF_ROLE_RST, SSF_IGN_RST});
    chk("rx_data", rx_data, SSF_DATA_RST);
    chk("rx_stall", {7'h00, rx_stall}, 8'h00);
  endtask

  task automatic t_done();
    cpu(4'h1, 8'h00, 3'b100);
    // the link side leaves its local reset only on link edges
    link.idle_clocks(2);
    link.send(8'h96, 8, 1'b1);
    wait_st(SSF_ST_DONE);
    chk("status", status, 8'h80);
    chk("rx_data", rx_data, 8'h96);
    chk("irq", irqv, 8'h05);
    cpu(4'h2, 8'h00, 3'b100);
    cpu(4'h4, 8'h00, 3'b100);
    chk("status", status, 8'h00);
    chk("irq", irqv, 8'h00);
  endtask

  // three bytes in one frame, done never cleared in between
  task automatic t_overrun();
    link.send(8'h11, 8, 1'b0);
    link.send(8'h22, 8, 1'b0);
    link.send(8'h33, 8, 1'b1);
    cyc(20);
    chk("rx_data", rx_data, 8'h11);
    chk("status", status, 8'h80);
    chk("irq", irqv, 8'h05);
    cpu(4'h2, 8'h00, 3'b100);
    cpu(4'h4, 8'h00, 3'b100);
    cyc(20);
    chk("status", status, 8'h00);
  endtask

  // data write lands mid-byte, six rising link edges into the frame
  task automatic t_write_collision_flag();
    fork
      link.send(8'h5A, 8, 1'b1);
      begin
        #150;
        cpu(4'h8, 8'h3C, 3'b100);
        chk("status", status, 8'h40);
        chk("pins", {6'h00, miso_oe, miso}, 8'h02);
        chk("irq", irqv, 8'h00);
      end
    join
    wait_st(SSF_ST_DONE);
    chk("rx_data", rx_data, 8'h5A);
    chk("status", status, 8'hC0);
    cpu(4'h4, 8'h00, 3'b100);
    chk("status", status, 8'hC0);
    cpu(4'h2, 8'h00, 3'b100);
    cpu(4'h4, 8'h00, 3'b100);
    chk("status", status, 8'h00);
  endtask

  // select rises after four bits
  task automatic t_slave_select_error_flag();
    link.send(8'hF0, 4, 1'b1);
    cyc(10);
    chk("status", status, 8'h20);
    chk("irq", irqv, 8'h00);
    cpu(4'h1, 8'h00, 3'b100);
    chk("status", status, 8'h20);
    cpu(4'h1, 8'h00, 3'b000);
    chk("status", status, 8'h00);
    link.idle_clocks(2);
  endtask

  task automatic t_mode_fault_flag();
    cpu(4'h1, 8'h00, 3'b111);
    link.select(1'b0);
    cyc(10);
    chk("status", status, 8'h00);
    chk("irq", irqv, 8'h00);
    cpu(4'h1, 8'h00, 3'b110);
    cyc(5);
    chk("status", status, 8'h10);
    chk("irq", irqv, 8'h03);
    chk("ctrl", ctrlv, 8'h00);
    cpu(4'h1, 8'h00, 3'b001);
    chk("status", status, 8'h10);
    chk("irq", irqv, 8'h00);
    link.select(1'b1);
    cpu(4'h2, 8'h00, 3'b001);
    cpu(4'h1, 8'h00, 3'b000);
    chk("status", status, 8'h00);
    cpu(4'h1, 8'h00, 3'b100);
    chk("ctrl", ctrlv, 8'h04);
  endtask

  // ---------------------------------------------------------------
  // clock, sequence, watchdog and verdict
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reset runs link edges too so the link side settles
  initial begin
    rst_i = 1'b1;
    {data_wr, data_rd, status_rd, ctrl_wr} = 4'h0;
    wdata = 8'h00;
    {en_in, role_in, ign_in} = 3'b010;
    fork
      repeat (12) @(posedge clk_sys_i);
      link.idle_clocks(3);
    join
    #2 rst_i = 1'b0;
    t_reset();
    t_done();
    t_overrun();
    t_write_collision_flag();
    t_slave_select_error_flag();
    t_mode_fault_flag();
    summarize();
  end

  // whole run needs some 5 us; far beyond that counts as a hang
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule // test_spi_status_flags_and_irq
